// ===== bench/lrt_timer_monitor.sv
`timescale 1ns/1ps
module lrt_timer_monitor #(
	parameter int DOG_CYC = lrt_pkg::DOG_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [lrt_pkg::ADDR_W-1:0] addr,
	input wire logic [lrt_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [lrt_pkg::DATA_W-1:0] rd_data,
	input wire logic capture_pin,
	input wire logic irq,
	input wire logic dog_reset
);
	logic en_seen_r;
	int dog_age_r;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge mclk) begin
		if (rst || (wr_en && addr == lrt_pkg::ADDR_IEN))
			en_seen_r <= !rst;
	end
	// re-enabling a running watchdog is not tracked, so the bench avoids it
	always_ff @(posedge mclk) begin
		if (rst || (wr_en && (addr == lrt_pkg::ADDR_KICK || (addr == lrt_pkg::ADDR_CTRL && wr_data[1]))))
			dog_age_r <= 0;
		else
			dog_age_r <= dog_age_r + 1;
	end
	////////////////////////////////////////////////////////////////////////////////
	a_reset_quiet: assert property (
		$fell(rst) |-> rd_data == 8'h00 && !irq && !dog_reset) else $error("outputs busy after reset");
	a_read_idle: assert property (
		!rd_en |=> rd_data == 8'h00) else $error("read data outside read");
	a_reload_back: assert property (
		wr_en && addr == lrt_pkg::ADDR_RELOAD ##1 rd_en && addr == lrt_pkg::ADDR_RELOAD
		|=> rd_data == $past(wr_data, 2)) else $error("reload readback wrong");
	a_select_back: assert property (
		wr_en && addr == lrt_pkg::ADDR_CTRL ##1 rd_en && addr == lrt_pkg::ADDR_CTRL
		|=> rd_data[0] == $past(wr_data[0], 2)) else $error("timebase select readback wrong");
	a_irq_needs_en: assert property (
		!en_seen_r |-> !irq) else $error("irq with nothing enabled");
	a_off_drops_irq: assert property (
		wr_en && (addr == lrt_pkg::ADDR_IEN && wr_data == 8'h00 || addr == lrt_pkg::ADDR_OFF && wr_data[2:0] == 3'h7)
		|-> ##2 !irq) else $error("irq stays after enables cleared");
	a_dog_single: assert property (
		dog_reset |=> !dog_reset) else $error("watchdog pulse too long");
	a_dog_timing: assert property (
		dog_reset |-> dog_age_r >= DOG_CYC - 3 && dog_age_r <= DOG_CYC + 6) else $error("watchdog timeout off");
	a_dog_off_quiet: assert property (
		wr_en && addr == lrt_pkg::ADDR_OFF && wr_data[4] |-> ##3 !dog_reset [*8]) else $error("watchdog bit when off");
	c_irq: cover property (irq ##1 !irq);
	c_bite: cover property (dog_reset);
	c_count: cover property (rd_en && addr == lrt_pkg::ADDR_COUNT);
endmodule

bind lrt_timer lrt_timer_monitor #(.DOG_CYC(DOG_CYC)) u_mon (.mclk(mclk), .rst(rst), .addr(addr),
	.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .capture_pin(capture_pin),
	.irq(irq), .dog_reset(dog_reset));

// ===== bench/tb_lite_timebase_reload_timer.sv
`timescale 1ns/1ps
module tb_lite_timebase_reload_timer;
	localparam int DOG = 60;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [7:0] wr_data = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic capture_pin = 1'b0;
	logic [7:0] rd_data;
	logic irq;
	logic dog_reset;
	logic [7:0] v;
	logic [7:0] e;
	int error_cnt = 0;
	int n_compared = 0;
	int bites = 0;
	int n;

	lrt_timer #(.TB_SHORT_CYC(20), .TB_LONG_CYC(40), .DOG_CYC(DOG), .TICK_CYC(2)) dut (.mclk(mclk), .rst(rst),
		.addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
		.capture_pin(capture_pin), .irq(irq), .dog_reset(dog_reset));

	always #20 mclk = ~mclk;
	// counted off the sampling edge so checks never race the counter
	always @(negedge mclk) if (dog_reset === 1'b1) bites++;
	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge mclk);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		@(posedge mclk);
		d = rd_data;
	endtask
	// write then read the same place with no gap
	task automatic wrrd(input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
		wr(a, d);
		rd_en <= 1'b1;
		@(posedge mclk);
		rd_en <= 1'b0;
		@(posedge mclk);
		q = rd_data;
	endtask
	task automatic wait_irq;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (irq !== 1'b1 && n < 200);
	endtask
	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_defaults;
		for (int i = 0; i < 7; i++) begin
			rd(i == 6 ? 4'hF : 4'(i), v);
			check("reset value", v, 8'h00);
		end
		$display("done defaults");
	endtask
	task automatic t_reload;
		logic [7:0] vals [3] = '{8'h00, 8'hFF, 8'hA5};
		for (int i = 0; i < 3; i++) begin
			wrrd(lrt_pkg::ADDR_RELOAD, vals[i], v);
			check("reload", v, vals[i]);
		end
		wr(lrt_pkg::ADDR_RELOAD, 8'h10);
		rd(lrt_pkg::ADDR_COUNT, e);
		repeat (5) @(posedge mclk);
		rd(lrt_pkg::ADDR_COUNT, v);
		repeat (4) e = (e == 8'hFF) ? 8'h10 : e + 8'h01;
		check("count steps", v, e);
		wr(lrt_pkg::ADDR_RELOAD, 8'hFE);
		repeat (600) @(posedge mclk);
		rd(lrt_pkg::ADDR_COUNT, v);
		check("count wrap", v >> 1, 8'h7F);
		rd(lrt_pkg::ADDR_STAT, v);
		check("overflow flag", v & 8'h04, 8'h04);
		$display("done reload");
	endtask
	// first wait may hit a stale flag, second a period cut by the select change
	task automatic t_timebase;
		wr(lrt_pkg::ADDR_IEN, 8'h02);
		for (int s = 0; s < 2; s++) begin
			wrrd(lrt_pkg::ADDR_CTRL, 8'(s), v);
			check("select", v, 8'(s));
			repeat (2) begin
				wait_irq();
				wr(lrt_pkg::ADDR_CLR, 8'h02);
			end
			wait_irq();
			check("period", 8'(n + 2), s ? 8'h28 : 8'h14);
		end
		wr(lrt_pkg::ADDR_IEN, 8'h00);
		$display("done timebase");
	endtask
	task automatic t_enables;
		for (int i = 0; i < 3; i++) begin
			wr(lrt_pkg::ADDR_IEN, 8'h07);
			wr(lrt_pkg::ADDR_OFF, 8'h01 << i);
			rd(lrt_pkg::ADDR_IEN, v);
			check("one enable off", v, 8'h07 & ~(8'h01 << i));
		end
		// capture alone enabled, so the periodic flags cannot hide a missing capture irq
		wr(lrt_pkg::ADDR_IEN, 8'h01);
		repeat (2) @(posedge mclk);
		check("irq masked", {7'h0, irq}, 8'h00);
		capture_pin <= 1'b1;
		repeat (3) @(posedge mclk);
		capture_pin <= 1'b0;
		repeat (6) @(posedge mclk);
		check("irq on", {7'h0, irq}, 8'h01);
		wr(lrt_pkg::ADDR_OFF, 8'h07);
		repeat (2) @(posedge mclk);
		check("irq off", {7'h0, irq}, 8'h00);
		rd(lrt_pkg::ADDR_STAT, v);
		check("capture flag", v & 8'h01, 8'h01);
		wr(lrt_pkg::ADDR_CLR, 8'h01);
		rd(lrt_pkg::ADDR_STAT, v);
		check("capture clear", v & 8'h01, 8'h00);
		$display("done enables");
	endtask
	task automatic t_dog;
		wrrd(lrt_pkg::ADDR_CTRL, 8'h02, v);
		check("dog on", v & 8'h02, 8'h02);
		repeat (4) begin
			repeat (DOG - 20) @(posedge mclk);
			wr(lrt_pkg::ADDR_KICK, 8'h00);
		end
		wr(lrt_pkg::ADDR_OFF, 8'h10);
		repeat (2 * DOG) @(posedge mclk);
		check("kept quiet", 8'(bites), 8'h00);
		rd(lrt_pkg::ADDR_CTRL, v);
		check("dog off", v & 8'h02, 8'h00);
		wr(lrt_pkg::ADDR_CTRL, 8'h02);
		repeat (DOG - 6) @(posedge mclk);
		check("early bite", 8'(bites), 8'h00);
		repeat (14) @(posedge mclk);
		check("bite", 8'(bites), 8'h01);
		wr(lrt_pkg::ADDR_OFF, 8'h10);
		$display("done watchdog");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#200000;
		error_cnt++;
		report_and_stop();
	end
	initial begin
		repeat (5) @(posedge mclk);
		rst <= 1'b0;
		t_defaults();
		t_reload();
		t_timebase();
		t_enables();
		t_dog();
		report_and_stop();
	end
endmodule

// ===== verilog/lrt_dog.sv
`timescale 1ns/1ps
module lrt_dog #(
	parameter int DOG_CYC = lrt_pkg::DOG_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	lrt_tb_if.dog tb
);
	lrt_pkg::lrt_dog_state_type state_r;
	logic [lrt_pkg::DOG_CNT_W-1:0] left_r;

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_r <= lrt_pkg::LRT_DOG_IDLE;
			left_r <= '0;
			tb.dog_bite <= 1'b0;
		end else begin
			tb.dog_bite <= 1'b0;
			unique case (state_r)
				lrt_pkg::LRT_DOG_IDLE: begin
					left_r <= lrt_pkg::DOG_CNT_W'(DOG_CYC - 1);
					if (tb.dog_en) begin
						state_r <= lrt_pkg::LRT_DOG_RUN;
					end
				end
				lrt_pkg::LRT_DOG_RUN: begin
					if (!tb.dog_en) begin
						state_r <= lrt_pkg::LRT_DOG_IDLE;
					end else if (tb.dog_kick) begin
						left_r <= lrt_pkg::DOG_CNT_W'(DOG_CYC - 1);
					end else if (left_r == '0) begin
						state_r <= lrt_pkg::LRT_DOG_BITE;
						tb.dog_bite <= 1'b1;
					end else begin
						left_r <= left_r - 1'b1;
					end
				end
				lrt_pkg::LRT_DOG_BITE: begin
					// the reset it raises clears the enable, so it rests here until then
					if (!tb.dog_en) begin
						state_r <= lrt_pkg::LRT_DOG_IDLE;
					end
				end
				default: begin
					state_r <= lrt_pkg::LRT_DOG_IDLE;
				end
			endcase
		end
	end
endmodule

// ===== verilog/lrt_pace.sv
`timescale 1ns/1ps
module lrt_pace #(
	parameter int SHORT_CYC = lrt_pkg::TB_SHORT_CYC,
	parameter int LONG_CYC = lrt_pkg::TB_LONG_CYC
) (
	input wire logic mclk,
	input wire logic rst,
	lrt_tb_if.pace tb
);
	logic [lrt_pkg::TB_CNT_W-1:0] cyc_r;
	logic [lrt_pkg::TB_CNT_W-1:0] last;

	// a select change mid-period takes effect at once; the >= keeps a shrink safe
	assign last = tb.tb_long ? lrt_pkg::TB_CNT_W'(LONG_CYC - 1) : lrt_pkg::TB_CNT_W'(SHORT_CYC - 1);

	always_ff @(posedge mclk) begin
		if (rst) begin
			cyc_r <= '0;
			tb.tb_tick <= 1'b0;
		end else if (cyc_r >= last) begin
			cyc_r <= '0;
			tb.tb_tick <= 1'b1;
		end else begin
			cyc_r <= cyc_r + 1'b1;
			tb.tb_tick <= 1'b0;
		end
	end
endmodule

// ===== verilog/lrt_pkg.sv
// What this block does
// - software picks a timebase period of 1 ms or 2 ms
// - an 8-bit reload register takes any value from 00 to FF
// - reading the reload register returns it and leaves the timer untouched
// - on counter overflow the counter restarts from the reload value
// - software can read the live 8-bit counter at any time
// - a clearable capture interrupt enable suppresses capture interrupt requests
// - a timebase interrupt enable and a counter overflow interrupt enable, each clearable on its own
// - software can switch the watchdog off
// - enables are independent; one write may clear several of them together
// - after reset: 1 ms timebase, watchdog off, all interrupts off
// - watchdog expires 2 ms after its last refresh and then resets
package lrt_pkg;

	localparam int MCLK_NS = 40;
	localparam int NS_PER_MS = 1000000;
	localparam int TB_SHORT_MS = 1;
	localparam int TB_LONG_MS = 2;
	localparam int DOG_MS = 2;
	localparam int TICK_NS = 4000;
	localparam int TB_SHORT_CYC = TB_SHORT_MS * NS_PER_MS / MCLK_NS;
	localparam int TB_LONG_CYC = TB_LONG_MS * NS_PER_MS / MCLK_NS;
	localparam int DOG_CYC = DOG_MS * NS_PER_MS / MCLK_NS;
	localparam int TICK_CYC = TICK_NS / MCLK_NS;

	localparam int TB_CNT_W = 17;
	localparam int DOG_CNT_W = 17;
	localparam int TICK_W = 8;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int EV_W = 3;

	////////////////////////////////////////////////////////////////////////////////
	localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] ADDR_OFF = 4'h1;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h2;
	localparam logic [ADDR_W-1:0] ADDR_CLR = 4'h3;
	localparam logic [ADDR_W-1:0] ADDR_IEN = 4'h4;
	localparam logic [ADDR_W-1:0] ADDR_RELOAD = 4'h5;
	localparam logic [ADDR_W-1:0] ADDR_COUNT = 4'h6;
	localparam logic [ADDR_W-1:0] ADDR_KICK = 4'h7;

	localparam int BIT_TB_LONG = 0;
	localparam int BIT_DOG_EN = 1;
	localparam int EV_CAPT = 0;
	localparam int EV_ONE = 1;
	localparam int EV_TWO = 2;
	localparam int OFF_DOG = 4;

	localparam logic [DATA_W-1:0] RELOAD_RST = 8'h00;
	localparam logic [DATA_W-1:0] COUNT_RST = 8'h00;
	localparam logic [DATA_W-1:0] COUNT_TOP = 8'hFF;
	localparam logic [EV_W-1:0] EV_NONE = 3'h0;

	typedef enum logic [1:0] {
		LRT_DOG_IDLE = 2'b00,
		LRT_DOG_RUN = 2'b01,
		LRT_DOG_BITE = 2'b10
	} lrt_dog_state_type;

endpackage

// ===== verilog/lrt_tb_if.sv
`timescale 1ns/1ps
interface lrt_tb_if;
	logic tb_long;
	logic tb_tick;
	logic dog_en;
	logic dog_kick;
	logic dog_bite;

	modport pace (input tb_long, output tb_tick);
	modport dog (input dog_en, input dog_kick, output dog_bite);
	modport core (output tb_long, output dog_en, output dog_kick, input tb_tick, input dog_bite);
endinterface

// ===== verilog/lrt_timer.sv
`timescale 1ns/1ps
module lrt_timer #(
	parameter int TB_SHORT_CYC = lrt_pkg::TB_SHORT_CYC,
	parameter int TB_LONG_CYC = lrt_pkg::TB_LONG_CYC,
	parameter int DOG_CYC = lrt_pkg::DOG_CYC,
	parameter int TICK_CYC = lrt_pkg::TICK_CYC,
	parameter int TB_COUNT = 2
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [lrt_pkg::ADDR_W-1:0] addr,
	input wire logic [lrt_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [lrt_pkg::DATA_W-1:0] rd_data,
	input wire logic capture_pin,
	output logic irq,
	output logic dog_reset
);
	lrt_tb_if tb ();

	logic tb_long_r;
	logic dog_en_r;
	logic dog_kick_r;
	logic [lrt_pkg::EV_W-1:0] ien_r;
	logic [lrt_pkg::EV_W-1:0] stat_r;
	logic [lrt_pkg::EV_W-1:0] stat_nxt;
	logic [lrt_pkg::EV_W-1:0] events;
	logic [lrt_pkg::DATA_W-1:0] reload_r;
	logic [lrt_pkg::DATA_W-1:0] count_r;
	logic [lrt_pkg::TICK_W-1:0] div_r;
	logic tick_r;
	logic ovf_r;
	logic cap_meta_r;
	logic cap_sync_r;
	logic cap_prev_r;
	logic wr_ctrl;
	logic wr_off;
	logic wr_clr;
	logic wr_ien;

	////////////////////////////////////////////////////////////////////////////////
	// single-timebase variants keep no counter overflow enable
	function automatic logic [lrt_pkg::EV_W-1:0] ev_mask(input logic [lrt_pkg::EV_W-1:0] v);
		logic [lrt_pkg::EV_W-1:0] m;
		m = v;
		if (TB_COUNT < 2) begin
			m[lrt_pkg::EV_TWO] = 1'b0;
		end
		return m;
	endfunction

	function automatic logic hit(input logic [lrt_pkg::ADDR_W-1:0] a, input logic [lrt_pkg::ADDR_W-1:0] b);
		return a == b;
	endfunction

	assign wr_ctrl = wr_en && hit(addr, lrt_pkg::ADDR_CTRL);
	assign wr_off = wr_en && hit(addr, lrt_pkg::ADDR_OFF);
	assign wr_clr = wr_en && hit(addr, lrt_pkg::ADDR_CLR);
	assign wr_ien = wr_en && hit(addr, lrt_pkg::ADDR_IEN);

	assign tb.tb_long = tb_long_r;
	assign tb.dog_en = dog_en_r;
	assign tb.dog_kick = dog_kick_r;

	lrt_pace #(
		.SHORT_CYC(TB_SHORT_CYC),
		.LONG_CYC(TB_LONG_CYC)
	) u_pace (
		.mclk(mclk),
		.rst(rst),
		.tb(tb.pace)
	);

	lrt_dog #(
		.DOG_CYC(DOG_CYC)
	) u_dog (
		.mclk(mclk),
		.rst(rst),
		.tb(tb.dog)
	);

	////////////////////////////////////////////////////////////////////////////////
	// control: timebase select and watchdog enable
	always_ff @(posedge mclk) begin
		if (rst) begin
			tb_long_r <= 1'b0;
			dog_en_r <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				tb_long_r <= wr_data[lrt_pkg::BIT_TB_LONG];
			end
			if (wr_ctrl && wr_data[lrt_pkg::BIT_DOG_EN]) begin
				dog_en_r <= 1'b1;
			end else if (wr_off && wr_data[lrt_pkg::OFF_DOG]) begin
				dog_en_r <= 1'b0;
			end
		end
	end

	// interrupt enables: set by the enable register, cleared bit by bit by the off register
	always_ff @(posedge mclk) begin
		if (rst) begin
			ien_r <= lrt_pkg::EV_NONE;
		end else if (wr_ien) begin
			ien_r <= ev_mask(wr_data[lrt_pkg::EV_W-1:0]);
		end else if (wr_off) begin
			ien_r <= ien_r & ~wr_data[lrt_pkg::EV_W-1:0];
		end
	end

	// any write to the kick address restarts the watchdog
	always_ff @(posedge mclk) begin
		if (rst) begin
			dog_kick_r <= 1'b0;
		end else begin
			dog_kick_r <= wr_en && hit(addr, lrt_pkg::ADDR_KICK);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reload register
	always_ff @(posedge mclk) begin
		if (rst) begin
			reload_r <= lrt_pkg::RELOAD_RST;
		end else if (wr_en && hit(addr, lrt_pkg::ADDR_RELOAD)) begin
			reload_r <= wr_data;
		end
	end

	// count prescaler
	always_ff @(posedge mclk) begin
		if (rst) begin
			div_r <= '0;
			tick_r <= 1'b0;
		end else if (div_r == lrt_pkg::TICK_W'(TICK_CYC - 1)) begin
			div_r <= '0;
			tick_r <= 1'b1;
		end else begin
			div_r <= div_r + 1'b1;
			tick_r <= 1'b0;
		end
	end

	// 8-bit counter, restarts from the reload value after FF
	always_ff @(posedge mclk) begin
		if (rst) begin
			count_r <= lrt_pkg::COUNT_RST;
			ovf_r <= 1'b0;
		end else begin
			ovf_r <= 1'b0;
			if (tick_r) begin
				if (count_r == lrt_pkg::COUNT_TOP) begin
					count_r <= reload_r;
					ovf_r <= 1'b1;
				end else begin
					count_r <= count_r + 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// capture pin: two flops, then edge detect on the second
	always_ff @(posedge mclk) begin
		if (rst) begin
			cap_meta_r <= 1'b0;
			cap_sync_r <= 1'b0;
			cap_prev_r <= 1'b0;
		end else begin
			cap_meta_r <= capture_pin;
			cap_sync_r <= cap_meta_r;
			cap_prev_r <= cap_sync_r;
		end
	end

	always_comb begin
		events = lrt_pkg::EV_NONE;
		events[lrt_pkg::EV_CAPT] = cap_sync_r && !cap_prev_r;
		events[lrt_pkg::EV_ONE] = tb.tb_tick;
		events[lrt_pkg::EV_TWO] = ovf_r && (TB_COUNT > 1);
		// a new event in the clearing cycle survives the clear
		stat_nxt = stat_r;
		if (wr_clr) begin
			stat_nxt = stat_nxt & ~wr_data[lrt_pkg::EV_W-1:0];
		end
		stat_nxt = stat_nxt | events;
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			stat_r <= lrt_pkg::EV_NONE;
		end else begin
			stat_r <= stat_nxt;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_nxt & ien_r);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			dog_reset <= 1'b0;
		end else begin
			dog_reset <= tb.dog_bite;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reads have no side effects; write-only and unmapped addresses read zero
	always_ff @(posedge mclk) begin
		if (rst) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= '0;
			unique case (addr)
				lrt_pkg::ADDR_CTRL: begin
					rd_data[lrt_pkg::BIT_TB_LONG] <= tb_long_r;
					rd_data[lrt_pkg::BIT_DOG_EN] <= dog_en_r;
				end
				lrt_pkg::ADDR_STAT: begin
					rd_data[lrt_pkg::EV_W-1:0] <= stat_r;
				end
				lrt_pkg::ADDR_IEN: begin
					rd_data[lrt_pkg::EV_W-1:0] <= ien_r;
				end
				lrt_pkg::ADDR_RELOAD: begin
					rd_data <= reload_r;
				end
				lrt_pkg::ADDR_COUNT: begin
					rd_data <= count_r;
				end
				default: begin
					rd_data <= '0;
				end
			endcase
		end else begin
			rd_data <= '0;
		end
	end
endmodule
